// [pkg/rgmii_port_pkg.sv]
// Constants, types and register map of the gigabit reduced-pin port block
// Overview of operation
// R1: MAC drives transmit clock at 125/25/2.5 MHz
// R2: Port drives receive clock at same rates; the code gives 100 MHz at gigabit, since the half period is held at one cycle
// R3: Gigabit nibbles travel on both clock edges
// R4: MAC holds control low until speeds match
// R5: Speed change stretches a receive clock phase
// R6: Control merges enable and error, error at fall
// R7: No automatic speed adaptation, strap or register
// R8: Strap picks gigabit or 100 at power-up
// R9: Register overrides speed: 1000, 100 or 10
// R10: Optional 1.5 ns delay on either clock; the code delays by one 5 ns system cycle
// R11: Ingress delay enable resets to off
// R12: Egress delay enable resets to on
// R13: Strap selects this interface mode after reset
// R14: Attached PHY should use a fixed speed
// R15: Separate transmit and receive groups, four bits
// R16: Half and full duplex at every speed
// R17: At 10/100 one nibble per clock cycle
package rgmii_port_pkg;

  typedef enum logic [1:0] {
    SPD_10   = 2'h0,
    SPD_100  = 2'h1,
    SPD_1000 = 2'h2
  } speed_t;

  typedef enum logic [1:0] {
    CK_RUN     = 2'h1,
    CK_STRETCH = 2'h2
  } ckgen_t;

  // Clock rates
  localparam int unsigned SYS_CLK_KHZ    = 200000;
  localparam int unsigned SYS_PERIOD_PS  = 5000;
  localparam int unsigned REF_1000_KHZ   = 125000;
  localparam int unsigned REF_100_KHZ    = 25000;
  localparam int unsigned REF_10_KHZ     = 2500;
  localparam int unsigned CLK_DELAY_PS   = 1500;

  // Half periods round down, never below one cycle
  localparam int unsigned HALF_W = 8;
  localparam logic [7:0] HALF_1000_CYC = (SYS_CLK_KHZ / (2 * REF_1000_KHZ)
    < 1) ? 8'h01 : 8'((SYS_CLK_KHZ / (2 * REF_1000_KHZ)));
  localparam logic [7:0] HALF_100_CYC  = (SYS_CLK_KHZ / (2 * REF_100_KHZ)
    < 1) ? 8'h01 : 8'((SYS_CLK_KHZ / (2 * REF_100_KHZ)));
  localparam logic [7:0] HALF_10_CYC   = (SYS_CLK_KHZ / (2 * REF_10_KHZ)
    < 1) ? 8'h01 : 8'((SYS_CLK_KHZ / (2 * REF_10_KHZ)));
  // Minimum delay rounds up
  localparam int unsigned DELAY_CYC =
    (CLK_DELAY_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TXCNT_OFS  = 8'h08;
  localparam logic [7:0] RXCNT_OFS  = 8'h0c;

  // Control fields
  localparam int unsigned CTRL_OVR_BIT   = 0;
  localparam int unsigned CTRL_SPD_LSB   = 1;
  localparam int unsigned CTRL_IGDLY_BIT = 3;
  localparam int unsigned CTRL_EGDLY_BIT = 4;
  localparam int unsigned CTRL_FDX_BIT   = 5;
  localparam logic [7:0]  CTRL_RESET     = 8'h34;

  // Status fields
  localparam int unsigned ST_SPD_LSB   = 0;
  localparam int unsigned ST_STRAP_BIT = 2;
  localparam int unsigned ST_MODE_BIT  = 3;
  localparam int unsigned ST_BUSY_BIT  = 4;
  localparam int unsigned ST_OVF_BIT   = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [core/pair_buffer.sv]
// Small valid/ready buffer, registered storage
`timescale 1ns/100ps
module pair_buffer #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end
endmodule

// [core/rgmii_port_interface.sv]
// Gigabit reduced-pin port, PHY side, with AXI4-Lite control
`timescale 1ns/100ps
module rgmii_port_interface
  import rgmii_port_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 2
) (
  // System
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Straps
  input  wire logic        mode_strap,
  input  wire logic        speed_strap,
  // Link transmit group, from MAC
  input  wire logic        tx_ref_clk_in,
  input  wire logic [3:0]  tx_nibble_in,
  input  wire logic        tx_control_in,
  // Link receive group, to MAC
  output logic             rx_ref_clk_out,
  output logic      [3:0]  rx_nibble_out,
  output logic             rx_control_out,
  // Received-from-MAC byte stream
  output logic      [7:0]  tx_byte,
  output logic             tx_byte_err,
  output logic             tx_byte_sof,
  output logic             tx_byte_valid,
  input  wire logic        tx_byte_ready,
  // Byte stream to send to MAC
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_byte_err,
  input  wire logic        rx_byte_valid,
  output logic             rx_byte_ready,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Pin synchronisers, transmit group kept apart (see R15)
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [1:0] strap_s1_r;
  logic [1:0] strap_s2_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      pin_s1_r   <= {tx_ref_clk_in, tx_control_in, tx_nibble_in};
      pin_s2_r   <= pin_s1_r;
      strap_s1_r <= {mode_strap, speed_strap};
      strap_s2_r <= strap_s1_r;
    end
  end

  // Straps caught once after reset release (see R8) (see R13)
  logic [1:0] strap_cnt_r;
  logic       strap_done_r;
  logic       mode_on_r;
  logic       strap_gig_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt_r  <= '0;
      strap_done_r <= 1'b0;
      mode_on_r    <= 1'b0;
      strap_gig_r  <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_SETTLE) begin
        strap_done_r <= 1'b1;
        mode_on_r    <= strap_s2_r[1];
        strap_gig_r  <= strap_s2_r[0];
      end
    end
  end

  // Registers
  logic [7:0]  ctrl_r;
  logic        ovf_r;
  logic [31:0] tx_cnt_r;
  logic [31:0] rx_cnt_r;
  logic        run_en;
  speed_t      cur_speed_r;
  speed_t      target;
  ckgen_t      ck_state_r;

  assign run_en = strap_done_r & mode_on_r;
  // Speed only from strap or software, never from the line (see R7)
  always_comb begin
    if (ctrl_r[CTRL_OVR_BIT]) begin
      case (ctrl_r[CTRL_SPD_LSB +: 2])
        2'h0:    target = SPD_10;
        2'h1:    target = SPD_100;
        default: target = SPD_1000;
      endcase // see R9
    end else begin
      // Live strap until caught, so power-up starts without a stretch
      target = (strap_done_r ? strap_gig_r : strap_s2_r[0]) ?
               SPD_1000 : SPD_100; // see R8
    end
  end

  // Ingress delay line on the sampled transmit clock (see R10) (see R11)
  logic [DELAY_CYC-1:0] ig_dly_r;
  logic               tx_clk_use;
  logic               tx_clk_prev_r;
  logic               tx_rise;
  logic               tx_fall;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ig_dly_r <= '0;
    end else begin
      ig_dly_r <= DELAY_CYC'({ig_dly_r, pin_s2_r[5]});
    end
  end
  assign tx_clk_use = ctrl_r[CTRL_IGDLY_BIT] ? ig_dly_r[DELAY_CYC-1]
                                             : pin_s2_r[5];
  assign tx_rise    = run_en & tx_clk_use & ~tx_clk_prev_r;
  assign tx_fall    = run_en & ~tx_clk_use & tx_clk_prev_r;

  // Transmit capture and byte assembly
  logic [3:0] nib_a_r;
  logic       en_a_r;
  logic [3:0] lo_r;
  logic       err_acc_r;
  logic       half_r;
  logic       in_frame_r;
  logic       tx_push;
  logic [9:0] tx_word;
  logic       tx_buf_ready;
  logic       fall_err;

  // Control at the falling edge is enable xor error (see R6)
  assign fall_err = pin_s2_r[4] ^ en_a_r;
  assign tx_push  = tx_fall & en_a_r &
                    ((cur_speed_r == SPD_1000) | half_r);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_clk_prev_r <= 1'b0;
      nib_a_r       <= '0;
      en_a_r        <= 1'b0;
      lo_r          <= '0;
      err_acc_r     <= 1'b0;
      half_r        <= 1'b0;
      in_frame_r    <= 1'b0;
      tx_word       <= '0;
    end else begin
      tx_clk_prev_r <= tx_clk_use;
      if (tx_rise) begin
        nib_a_r <= pin_s2_r[3:0];
        en_a_r  <= pin_s2_r[4];
      end
      if (tx_fall) begin
        if (!en_a_r) begin
          half_r     <= 1'b0;
          in_frame_r <= 1'b0;
        end else if (cur_speed_r == SPD_1000) begin
          // Low nibble at the rise, high nibble at the fall (see R3)
          tx_word    <= {~in_frame_r, fall_err, pin_s2_r[3:0], nib_a_r};
          in_frame_r <= 1'b1;
        end else if (!half_r) begin
          // One nibble per cycle, taken at the rise (see R17)
          lo_r      <= nib_a_r;
          err_acc_r <= fall_err;
          half_r    <= 1'b1;
        end else begin
          tx_word    <= {~in_frame_r, err_acc_r | fall_err, nib_a_r, lo_r};
          half_r     <= 1'b0;
          in_frame_r <= 1'b1;
        end
      end
    end
  end

  // The word lands one cycle after tx_push
  logic tx_push_d_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_push_d_r <= 1'b0;
    end else begin
      tx_push_d_r <= tx_push;
    end
  end

  // The MAC cannot be stalled; a full buffer drops the byte and flags it
  pair_buffer #(.WIDTH(10), .DEPTH(BUF_DEPTH)) u_tx_buf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_data   (tx_word),
    .in_valid  (tx_push_d_r),
    .in_ready  (tx_buf_ready),
    .out_data  ({tx_byte_sof, tx_byte_err, tx_byte}),
    .out_valid (tx_byte_valid),
    .out_ready (tx_byte_ready)
  );

  // Receive clock generator (see R2)
  logic [HALF_W-1:0] ck_cnt_r;
  logic              rxc_r;
  logic              toggle;
  logic              rx_rise;
  logic              rx_fall;

  function automatic logic [HALF_W-1:0] half_of(input speed_t s);
    case (s)
      SPD_1000: half_of = HALF_1000_CYC;
      SPD_100:  half_of = HALF_100_CYC;
      default:  half_of = HALF_10_CYC;
    endcase
  endfunction

  assign toggle  = run_en & (ck_cnt_r == '0) &
                   ((ck_state_r == CK_STRETCH) | (target == cur_speed_r));
  assign rx_rise = toggle & ~rxc_r;
  assign rx_fall = toggle & rxc_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ck_state_r  <= CK_RUN;
      ck_cnt_r    <= '0;
      rxc_r       <= 1'b0;
      cur_speed_r <= SPD_100;
    end else if (!run_en) begin
      ck_state_r  <= CK_RUN;
      ck_cnt_r    <= '0;
      rxc_r       <= 1'b0;
      cur_speed_r <= target;
    end else begin
      case (ck_state_r)
        CK_RUN: begin
          if (ck_cnt_r != '0) begin
            ck_cnt_r <= ck_cnt_r - 1'b1;
          end else if (target != cur_speed_r) begin
            // Hold the level one slowest half period extra (see R5)
            ck_state_r <= CK_STRETCH;
            ck_cnt_r   <= HALF_10_CYC - 1'b1;
          end else begin
            rxc_r    <= ~rxc_r;
            ck_cnt_r <= half_of(cur_speed_r) - 1'b1;
          end
        end
        CK_STRETCH: begin
          if (ck_cnt_r != '0) begin
            ck_cnt_r <= ck_cnt_r - 1'b1;
          end else begin
            ck_state_r  <= CK_RUN;
            cur_speed_r <= target; // see R5
            rxc_r       <= ~rxc_r;
            ck_cnt_r    <= half_of(target) - 1'b1;
          end
        end
        default: begin
          ck_state_r <= CK_RUN;
          ck_cnt_r   <= '0;
        end
      endcase
    end
  end

  // Egress delay line on the driven receive clock (see R10) (see R12)
  logic [DELAY_CYC-1:0] eg_dly_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      eg_dly_r <= '0;
    end else begin
      eg_dly_r <= DELAY_CYC'({eg_dly_r, rxc_r});
    end
  end
  assign rx_ref_clk_out = ctrl_r[CTRL_EGDLY_BIT] ? eg_dly_r[DELAY_CYC-1]
                                                 : rxc_r;

  // Receive byte buffer and nibble output
  logic [8:0] rx_head;
  logic       rx_head_valid;
  logic       rx_pop;
  logic [7:0] cur_byte_r;
  logic       cur_dv_r;
  logic       cur_er_r;
  logic       rx_half_r;

  pair_buffer #(.WIDTH(9), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_data   ({rx_byte_err, rx_byte}),
    .in_valid  (rx_byte_valid),
    .in_ready  (rx_byte_ready),
    .out_data  (rx_head),
    .out_valid (rx_head_valid),
    .out_ready (rx_pop)
  );

  assign rx_pop = rx_rise & rx_head_valid &
                  ((cur_speed_r == SPD_1000) | ~rx_half_r);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur_byte_r     <= '0;
      cur_dv_r       <= 1'b0;
      cur_er_r       <= 1'b0;
      rx_half_r      <= 1'b0;
      rx_nibble_out  <= '0;
      rx_control_out <= 1'b0;
    end else if (!run_en) begin
      rx_half_r      <= 1'b0;
      cur_dv_r       <= 1'b0;
      rx_nibble_out  <= '0;
      rx_control_out <= 1'b0;
    end else if (rx_rise) begin
      if ((cur_speed_r != SPD_1000) && rx_half_r) begin
        // Second nibble of a slow byte (see R17)
        rx_nibble_out  <= cur_byte_r[7:4];
        rx_control_out <= cur_dv_r;
        rx_half_r      <= 1'b0;
      end else begin
        cur_byte_r     <= rx_head[7:0];
        cur_dv_r       <= rx_head_valid;
        cur_er_r       <= rx_head[8];
        rx_nibble_out  <= rx_head_valid ? rx_head[3:0] : 4'h0;
        rx_control_out <= rx_head_valid;
        rx_half_r      <= rx_head_valid & (cur_speed_r != SPD_1000);
      end
    end else if (rx_fall) begin
      if (cur_speed_r == SPD_1000) begin
        rx_nibble_out <= cur_byte_r[7:4]; // see R3
      end
      rx_control_out <= cur_dv_r & ~cur_er_r; // see R6
    end
  end

  // AXI4-Lite write path
  logic       aw_have_r;
  logic       w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       do_write;
  logic       wr_ctrl;
  logic       wr_stat;

  // No new write is taken while its response is still pending
  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign do_write      = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_ctrl       = do_write & (aw_addr_r == CTRL_OFS) & w_strb_r[0];
  assign wr_stat       = do_write & (aw_addr_r == STATUS_OFS) & w_strb_r[0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= '0;
      w_data_r     <= '0;
      w_strb_r     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r > RXCNT_OFS) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; duplex bit is kept for software (see R16)
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET; // see R11 (see R12)
    end else if (wr_ctrl) begin
      ctrl_r <= {2'h0, w_data_r[5:0]};
    end
  end

  // Overflow is sticky; a new drop beats a clearing write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_r    <= 1'b0;
      tx_cnt_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (tx_push_d_r && !tx_buf_ready) begin
        ovf_r <= 1'b1;
      end else if (wr_stat && w_data_r[ST_OVF_BIT]) begin
        ovf_r <= 1'b0;
      end
      if (tx_push_d_r && tx_buf_ready) begin
        tx_cnt_r <= tx_cnt_r + 32'h1;
      end
      if (rx_pop) begin
        rx_cnt_r <= rx_cnt_r + 32'h1;
      end
    end
  end

  // AXI4-Lite read path
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      CTRL_OFS:   rd_mux = {24'h0, ctrl_r};
      STATUS_OFS: rd_mux = {26'h0, ovf_r, ck_state_r == CK_STRETCH,
                            mode_on_r, strap_gig_r, cur_speed_r};
      TXCNT_OFS:  rd_mux = tx_cnt_r;
      RXCNT_OFS:  rd_mux = rx_cnt_r;
      default:    rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [testbench/rgmii_port_sva.sv]
// Register bus and byte stream checker for the port
`timescale 1ns/100ps
module rgmii_port_sva
  import rgmii_port_pkg::*;
(
  // System
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Byte stream
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_byte_valid,
  input wire logic        tx_byte_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic wr_go;
  logic rd_go;
  assign wr_go = s_axi_awvalid && s_axi_awready &&
                 s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  a_write_resp_time: assert property (wr_go
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after request");
  a_write_okay: assert property (wr_go && s_axi_awaddr <= 8'h0f
    |-> ##2 s_axi_bresp == RESP_OKAY)
    else $error("mapped write not answered okay");
  a_write_unmapped: assert property (wr_go && s_axi_awaddr > 8'h0f
    |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_write_blocked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_bresp_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("write response not released");
  a_read_resp_time: assert property (rd_go |=> s_axi_rvalid)
    else $error("read data late");
  a_read_unmapped: assert property (rd_go && s_axi_araddr > 8'h0f
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_stream_hold: assert property (tx_byte_valid && !tx_byte_ready
    |=> tx_byte_valid && $stable(tx_byte))
    else $error("stalled byte changed or vanished");
endmodule

bind rgmii_port_interface rgmii_port_sva chk_u (.*);

// [testbench/mac_model.sv]
// Behavioural MAC facing the port's link pins
`timescale 1ns/100ps
module mac_model (
  // System
  input  wire logic       sys_clk,
  // Toward port
  output logic            tx_clk,
  output logic      [3:0] tx_nib,
  output logic            tx_ctl,
  // From port
  input  wire logic       rx_clk,
  input  wire logic [3:0] rx_nib,
  input  wire logic       rx_ctl
);
  logic [8:0] rx_q[$];
  int         per = 0;
  int         cnt = 0;
  logic       pc = 1'b0;
  logic       rc = 1'b0;
  logic       er = 1'b0;
  logic       half = 1'b0;
  logic [3:0] lo = 4'h0;

  initial begin
    tx_clk = 1'b0; // Clock stands still between frames
    tx_nib = 4'h0;
    tx_ctl = 1'b0; // Held low until speeds agree
  end

  // One 160 ns clock period, data changed midway between edges
  task automatic cyc1(input logic [3:0] n0, input logic c0,
                      input logic [3:0] n1, input logic c1);
    tx_nib = n0;
    tx_ctl = c0;
    #40 tx_clk = 1'b1;
    #40 tx_nib = n1;
    tx_ctl = c1; // Enable xor error at the fall
    #40 tx_clk = 1'b0;
    #40;
  endtask

  task automatic send(input logic [23:0] d, input int n,
                      input logic [2:0] e, input logic g);
    int i;
    for (i = 0; i < n; i++) begin
      if (g) begin
        cyc1(d[8*i+:4], 1'b1, d[8*i+4+:4], ~e[i]);
      end else begin
        cyc1(d[8*i+:4], 1'b1, d[8*i+:4], ~e[i]);
        cyc1(d[8*i+4+:4], 1'b1, d[8*i+4+:4], ~e[i]);
      end
    end
    // Idle periods end the frame; data lines show the last nibble inverted, then the last nibble again
    cyc1(~tx_nib, 1'b0, ~tx_nib, 1'b0);
    cyc1(~tx_nib, 1'b0, ~tx_nib, 1'b0);
  endtask

  // Receive capture valid at 10/100 only: one nibble per rise
  always @(posedge sys_clk) begin
    if (rx_clk === 1'b1 && pc === 1'b0) begin
      per = cnt;
      cnt = 0;
      rc = rx_ctl;
      if (rx_ctl !== 1'b1) begin
        half = 1'b0;
      end else if (!half) begin
        lo = rx_nib;
        half = 1'b1;
        er = 1'b0;
      end else begin
        rx_q.push_back({er, rx_nib, lo});
        half = 1'b0;
      end
    end
    if (rx_clk === 1'b0 && pc === 1'b1 && rc) begin
      er = er | (rc ^ rx_ctl);
    end
    cnt = cnt + 1;
    pc = rx_clk;
  end
endmodule

// [testbench/tb_rgmii_port_interface.sv]
// Self-checking bench for the reduced gigabit port
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_rgmii_port_interface
  import rgmii_port_pkg::*;
;
  logic sys_clk, nrst, mode_strap, speed_strap, tx_ref_clk_in, tx_control_in;
  logic rx_ref_clk_out, rx_control_out, tx_byte_err, tx_byte_sof;
  logic tx_byte_valid, tx_byte_ready, rx_byte_err, rx_byte_valid;
  logic rx_byte_ready, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  tx_nibble_in, rx_nibble_out, s_axi_wstrb;
  logic [7:0]  tx_byte, rx_byte, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  got_q[$];
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;

  rgmii_port_interface dut_u (.*);
  mac_model mac_u (.sys_clk(sys_clk), .tx_clk(tx_ref_clk_in),
    .tx_nib(tx_nibble_in), .tx_ctl(tx_control_in), .rx_clk(rx_ref_clk_out),
    .rx_nib(rx_nibble_out), .rx_ctl(rx_control_out));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      wrap_up();
    end
    if (tx_byte_valid === 1'b1 && tx_byte_ready)
      got_q.push_back({tx_byte_sof, tx_byte_err, tx_byte});
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_tx(input logic [23:0] d, input int n,
                        input logic [2:0] e);
    logic [9:0] v;
    while (got_q.size() < n) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      v = got_q.pop_front();
      `CHK(v, {i == 0, e[i], d[8*i+:8]})
    end
  endtask

  task automatic t_reset_and_bus();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(CTRL_OFS, d, r);
    `CHK(d, 32'h34)
    axi_rd(STATUS_OFS, d, r);
    `CHK(d[3:0], 4'he)
    axi_wr(8'h10, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    axi_rd(8'h10, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
  endtask

  task automatic t_overflow();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge sys_clk);
    tx_byte_ready <= 1'b0;
    mac_u.send(24'h332211, 3, 3'b000, 1'b1);
    axi_rd(STATUS_OFS, d, r);
    `CHK(d[5], 1'b1)
    axi_wr(STATUS_OFS, 32'h20, r);
    axi_rd(STATUS_OFS, d, r);
    `CHK(d[5], 1'b0)
    tx_byte_ready <= 1'b1;
    chk_tx(24'h002211, 2, 3'b000);
  endtask

  task automatic t_speed();
    speed_t      sp[3] = '{SPD_10, SPD_1000, SPD_100};
    logic [31:0] v, d;
    logic [1:0]  r;
    int          p;
    for (int s = 0; s < 3; s++) begin
      v = {26'h0, s[0] == 1'b0, 2'b10, sp[s], 1'b1};
      // MAC idle and fixed while speed moves
      axi_wr(CTRL_OFS, v, r);
      repeat (400) @(posedge sys_clk);
      axi_rd(CTRL_OFS, d, r);
      `CHK(d, v)
      axi_rd(STATUS_OFS, d, r);
      `CHK(d[1:0], sp[s])
      p = sp[s] == SPD_10 ? int'(HALF_10_CYC) :
          sp[s] == SPD_100 ? int'(HALF_100_CYC) : int'(HALF_1000_CYC);
      `CHK(mac_u.per, 2 * p)
    end
  endtask

  task automatic t_slow_link();
    logic [23:0] b = 24'h7fe13c;
    mac_u.send(24'h00a596, 2, 3'b001, 1'b0);
    chk_tx(24'h00a596, 2, 3'b001);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      rx_byte <= b[8*i+:8];
      rx_byte_err <= i == 1;
      rx_byte_valid <= 1'b1;
      do @(posedge sys_clk); while (rx_byte_ready !== 1'b1);
      rx_byte_valid <= 1'b0;
    end
    while (mac_u.rx_q.size() < 3) @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      `CHK(mac_u.rx_q[i], {i == 1, b[8*i+:8]})
    end
  endtask

  initial begin
    nrst = 1'b0;
    mode_strap = 1'b1;
    speed_strap = 1'b1;
    tx_byte_ready = 1'b1;
    {rx_byte, rx_byte_err, rx_byte_valid} = 10'h0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 42'h0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 11'h0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset_and_bus();
    mac_u.send(24'h81c35a, 3, 3'b010, 1'b1);
    chk_tx(24'h81c35a, 3, 3'b010);
    t_overflow();
    t_speed();
    t_slow_link();
    wrap_up();
  end
endmodule
